// ### logic/ssr_consts.vh
// Constants for the sensor serial control port and its shadow store.
// Assumes inclusion by the design modules, the checker and the bench.
`ifndef SSR_CONSTS_VH
`define SSR_CONSTS_VH
// ----------------------------------------
// Framing
// ----------------------------------------
`define SSR_ADDR_BITS 16
`define SSR_DATA_BITS 16
`define SSR_FRAME_BITS 32
`define SSR_WR_BIT 0
// ----------------------------------------
// Sensor states
// ----------------------------------------
`define SSR_ST_STANDBY 2'h0
`define SSR_ST_CONFIG 2'h1
`define SSR_ST_IDLE 2'h2
`define SSR_ST_RUNNING 2'h3
// ----------------------------------------
// Write classes
// ----------------------------------------
`define SSR_CL_ANY 2'h0
`define SSR_CL_CFG_IDLE 2'h1
`define SSR_CL_CFG_ONLY 2'h2
`define SSR_CL_STANDBY 2'h3
// ----------------------------------------
// Register slots and addresses
// ----------------------------------------
`define SSR_SLOT_BITS 3
`define SSR_ADR_LINE_LEN 16'h0200
`define SSR_ADR_LVDS_SEL 16'h2449
`define SSR_ADR_TEST_PAT 16'h2499
`define SSR_ADR_DEFECT 16'h2561
`define SSR_ADR_STBY_A 16'h4018
`define SSR_ADR_STBY_B 16'h4060
`define SSR_RST_LINE_LEN 16'h0000
`define SSR_RST_LVDS_SEL 16'h0432
`define SSR_RST_TEST_PAT 16'h0011
`define SSR_RST_DEFECT 16'h0006
`define SSR_RST_STBY 16'h0000
`define SSR_LVDS_SUB_BIT 0
// ----------------------------------------
// Fetch latency
// ----------------------------------------
`define SSR_CLK_MHZ 250
`define SSR_FETCH_CFG_NS 1500
`define SSR_FETCH_RUN_NS 4500
`define SSR_FETCH_CFG_CYC ((`SSR_FETCH_CFG_NS * `SSR_CLK_MHZ) / 1000)
`define SSR_FETCH_RUN_CYC ((`SSR_FETCH_RUN_NS * `SSR_CLK_MHZ) / 1000)
`endif

// ### logic/ssr_store.v
// Small register memory holding the shadow copy of each slot.
// Assumes one write port per copy and a registered read port.
`timescale 1ns/100ps
`include "ssr_consts.vh"
module ssr_store #(
  parameter SLOTS = 6,
  parameter AW = 3,
  parameter DW = 16
) (
  input wire ref_clk_in,
  input wire rstn_in,
  input wire ce_in,
  input wire wr_en_in,
  input wire [AW-1:0] wr_slot_in,
  input wire [DW-1:0] wr_data_in,
  input wire [AW-1:0] rd_slot_in,
  input wire rd_en_in,
  input wire [DW-1:0] rst_val_in,
  input wire [AW-1:0] init_slot_in,
  input wire init_in,
  output reg [DW-1:0] rd_data_out
);
  reg [DW-1:0] mem_ff [0:SLOTS-1];
  // Init loads a reset value slot by slot, so the array needs no async reset.
  always @(posedge ref_clk_in) begin
    if (ce_in) begin
      if (init_in) begin
        mem_ff[init_slot_in] <= rst_val_in;
      end else if (wr_en_in) begin
        mem_ff[wr_slot_in] <= wr_data_in;
      end
    end
  end
  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_data_out <= {DW{1'b0}};
    end else if (ce_in && rd_en_in) begin
      rd_data_out <= mem_ff[rd_slot_in];
    end
  end
endmodule

// ### logic/ssr_spi_slave.v
// Serial control slave of the sensor with shadow and active settings.
// Assumes sensor state and frame start come from sensor logic on ref_clk_in.
`timescale 1ns/100ps
`include "ssr_consts.vh"
module ssr_spi_slave #(
  parameter FETCH_RUN_CYC = `SSR_FETCH_RUN_CYC
) (
  input wire ref_clk_in,
  input wire rstn_in,
  input wire ce_in,
  input wire csn_in,
  input wire sck_in,
  input wire mosi_in,
  output reg miso_out,
  output reg miso_oe_out,
  input wire [1:0] sensor_state_in,
  input wire frame_start_in,
  output reg [15:0] line_length_setting_out,
  output reg sub_lvds_en_out,
  output reg [15:0] test_pattern_out,
  output reg [15:0] defect_enable_out,
  output reg write_refused_out,
  output reg fetch_busy_out
);
  localparam SLOTS = 6;
  localparam integer CFG_N = `SSR_FETCH_CFG_CYC;
  localparam integer RUN_N = FETCH_RUN_CYC;
  localparam [13:0] CFG_CYC = CFG_N[13:0];
  localparam [13:0] RUN_CYC = RUN_N[13:0];
  localparam [15:0] LV_RST = `SSR_RST_LVDS_SEL;
  // ----------------------------------------
  // Slot decode
  // ----------------------------------------
  function [3:0] slot_of;
    input [15:0] a;
    begin
      case (a)
        `SSR_ADR_LINE_LEN: slot_of = 4'h0;
        `SSR_ADR_LVDS_SEL: slot_of = 4'h1;
        `SSR_ADR_TEST_PAT: slot_of = 4'h2;
        `SSR_ADR_DEFECT: slot_of = 4'h3;
        `SSR_ADR_STBY_A: slot_of = 4'h4;
        `SSR_ADR_STBY_B: slot_of = 4'h5;
        default: slot_of = 4'h8;
      endcase
    end
  endfunction
  function [1:0] class_of;
    input [2:0] s;
    begin
      case (s)
        3'h0, 3'h1: class_of = `SSR_CL_CFG_ONLY;
        3'h2: class_of = `SSR_CL_CFG_IDLE;
        3'h3: class_of = `SSR_CL_ANY;
        default: class_of = `SSR_CL_STANDBY;
      endcase
    end
  endfunction
  function [15:0] rst_of;
    input [2:0] s;
    begin
      case (s)
        3'h0: rst_of = `SSR_RST_LINE_LEN;
        3'h1: rst_of = `SSR_RST_LVDS_SEL;
        3'h2: rst_of = `SSR_RST_TEST_PAT;
        3'h3: rst_of = `SSR_RST_DEFECT;
        default: rst_of = `SSR_RST_STBY;
      endcase
    end
  endfunction
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // slave inputs only
  reg [2:0] csn_sync_ff, sck_sync_ff, mosi_sync_ff;
  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      csn_sync_ff <= 3'h7;
      sck_sync_ff <= 3'h7;
      mosi_sync_ff <= 3'h0;
    end else if (ce_in) begin
      csn_sync_ff <= {csn_sync_ff[1:0], csn_in};
      sck_sync_ff <= {sck_sync_ff[1:0], sck_in};
      mosi_sync_ff <= {mosi_sync_ff[1:0], mosi_in};
    end
  end
  reg csn_ff, sck_ff, mosi_ff;
  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      csn_ff <= 1'b1;
      sck_ff <= 1'b1;
      mosi_ff <= 1'b0;
    end else if (ce_in) begin
      if (csn_sync_ff[1] == csn_sync_ff[2]) csn_ff <= csn_sync_ff[2];
      if (sck_sync_ff[1] == sck_sync_ff[2]) sck_ff <= sck_sync_ff[2];
      if (mosi_sync_ff[1] == mosi_sync_ff[2]) mosi_ff <= mosi_sync_ff[2];
    end
  end
  wire [2:0] sck_next = sck_sync_ff;
  wire sck_rise = !sck_ff && sck_next[1] && sck_next[2];
  wire sck_fall = sck_ff && !sck_next[1] && !sck_next[2];
  wire selected = !csn_ff;
  // ----------------------------------------
  // Frame shifter
  // ----------------------------------------
  reg [5:0] bit_cnt_ff;
  reg [15:0] addr_ff;
  reg [15:0] data_ff;
  reg [15:0] tx_ff;
  reg frame_done_ff;
  reg [13:0] fetch_cnt_ff;
  reg rd_req_ff;
  wire [15:0] rd_data;
  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bit_cnt_ff <= 6'h00;
      addr_ff <= 16'h0000;
      data_ff <= 16'h0000;
      frame_done_ff <= 1'b0;
      rd_req_ff <= 1'b0;
    end else if (ce_in) begin
      frame_done_ff <= 1'b0;
      rd_req_ff <= 1'b0;
      if (!selected) begin
        bit_cnt_ff <= 6'h00;
      end else if (sck_rise && bit_cnt_ff < 6'd32) begin
        if (bit_cnt_ff < 6'd16) begin
          addr_ff <= {addr_ff[14:0], mosi_ff};
        end else begin
          data_ff <= {data_ff[14:0], mosi_ff};
        end
        bit_cnt_ff <= bit_cnt_ff + 6'h01;
        rd_req_ff <= (bit_cnt_ff == 6'd15);
        frame_done_ff <= (bit_cnt_ff == 6'd31);
      end
    end
  end
  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fetch_cnt_ff <= 14'h0000;
      fetch_busy_out <= 1'b0;
    end else if (ce_in) begin
      if (rd_req_ff) begin
        fetch_cnt_ff <= (sensor_state_in == `SSR_ST_RUNNING) ?
                        RUN_CYC : CFG_CYC;
        fetch_busy_out <= 1'b1;
      end else if (fetch_cnt_ff != 14'h0000) begin
        fetch_cnt_ff <= fetch_cnt_ff - 14'h0001;
        fetch_busy_out <= (fetch_cnt_ff != 14'h0001);
      end else begin
        fetch_busy_out <= 1'b0;
      end
    end
  end
  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_ff <= 16'h0000;
      miso_out <= 1'b0;
      miso_oe_out <= 1'b0;
    end else if (ce_in) begin
      miso_oe_out <= selected;
      if (fetch_busy_out && fetch_cnt_ff == 14'h0001) begin
        tx_ff <= rd_data;
      end else if (selected && sck_fall && bit_cnt_ff >= 6'd16) begin
        miso_out <= tx_ff[15];
        tx_ff <= {tx_ff[14:0], 1'b0};
      end
    end
  end
  // ----------------------------------------
  // Write acceptance
  // ----------------------------------------
  wire [3:0] wslot = slot_of(addr_ff);
  wire [1:0] wclass = class_of(wslot[2:0]);
  reg accept;
  always @* begin
    accept = 1'b0;
    if (!wslot[3]) begin
      case (sensor_state_in)
        `SSR_ST_STANDBY: accept = (wclass == `SSR_CL_STANDBY);
        `SSR_ST_IDLE: accept = (wclass != `SSR_CL_CFG_ONLY);
        default: accept = 1'b1;
      endcase
    end
  end
  reg [2:0] init_ff;
  reg init_busy_ff;
  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      init_ff <= 3'h0;
      init_busy_ff <= 1'b1;
      write_refused_out <= 1'b0;
    end else if (ce_in) begin
      write_refused_out <= frame_done_ff && !accept;
      if (init_busy_ff) begin
        init_ff <= init_ff + 3'h1;
        init_busy_ff <= (init_ff != 3'd5);
      end
    end
  end
  wire do_write = frame_done_ff && accept && !init_busy_ff;
  wire [2:0] rslot = wslot[3] ? 3'h4 : wslot[2:0];
  ssr_store #(.SLOTS(SLOTS), .AW(3), .DW(16)) u_shadow (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .wr_en_in(do_write),
    .wr_slot_in(wslot[2:0]),
    .wr_data_in(data_ff),
    .rd_slot_in(rslot),
    .rd_en_in(rd_req_ff),
    .rst_val_in(rst_of(init_ff)),
    .init_slot_in(init_ff),
    .init_in(init_busy_ff),
    .rd_data_out(rd_data)
  );
  // ----------------------------------------
  // Shadow to active transfer
  // ----------------------------------------
  // Parallel pending copies of slots 0 to 3 let each be committed on its slot's event: config entry, config or idle entry, or frame start.
  reg [15:0] pend_ll_ff, pend_lv_ff, pend_tp_ff, pend_df_ff;
  reg [1:0] prev_state_ff;
  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pend_ll_ff <= `SSR_RST_LINE_LEN;
      pend_lv_ff <= `SSR_RST_LVDS_SEL;
      pend_tp_ff <= `SSR_RST_TEST_PAT;
      pend_df_ff <= `SSR_RST_DEFECT;
      prev_state_ff <= `SSR_ST_STANDBY;
      line_length_setting_out <= `SSR_RST_LINE_LEN;
      sub_lvds_en_out <= LV_RST[`SSR_LVDS_SUB_BIT];
      test_pattern_out <= `SSR_RST_TEST_PAT;
      defect_enable_out <= `SSR_RST_DEFECT;
    end else if (ce_in) begin
      prev_state_ff <= sensor_state_in;
      if (do_write) begin
        case (wslot[2:0])
          3'h0: pend_ll_ff <= data_ff;
          3'h1: pend_lv_ff <= data_ff;
          3'h2: pend_tp_ff <= data_ff;
          3'h3: pend_df_ff <= data_ff;
          default: ;
        endcase
      end
      if (frame_start_in) begin
        defect_enable_out <= pend_df_ff;
      end
      if (sensor_state_in != prev_state_ff) begin
        if (sensor_state_in == `SSR_ST_CONFIG) begin
          line_length_setting_out <= pend_ll_ff;
          sub_lvds_en_out <= pend_lv_ff[`SSR_LVDS_SUB_BIT];
        end
        if (sensor_state_in == `SSR_ST_CONFIG ||
            sensor_state_in == `SSR_ST_IDLE) begin
          test_pattern_out <= pend_tp_ff;
        end
      end
    end
  end
endmodule

// ### tb/ssr_spi_checker.sv
// Assertions on the ports of the sensor serial slave.
// Assumes a bind into ssr_spi_slave and the shared header on the path.
`timescale 1ns/100ps
`include "ssr_consts.vh"
module ssr_spi_checker #(
  parameter FETCH_RUN_CYC = 1125
) (
  input wire ref_clk_in,
  input wire rstn_in,
  input wire ce_in,
  input wire csn_in,
  input wire sck_in,
  input wire mosi_in,
  input wire miso_out,
  input wire miso_oe_out,
  input wire [1:0] sensor_state_in,
  input wire frame_start_in,
  input wire [15:0] line_length_setting_out,
  input wire sub_lvds_en_out,
  input wire [15:0] test_pattern_out,
  input wire [15:0] defect_enable_out,
  input wire write_refused_out,
  input wire fetch_busy_out
);
  // Config fetch takes 375 cycles; the slack covers the pin synchronisers.
  localparam int FMAX = (FETCH_RUN_CYC > 375 ? FETCH_RUN_CYC : 375) + 16;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  wire cfg = sensor_state_in == `SSR_ST_CONFIG;
  wire idl = sensor_state_in == `SSR_ST_IDLE;
  localparam int CFG_MAX = `SSR_FETCH_CFG_CYC;
  // A running fetch can outlast the widest delay range, so it is counted.
  logic [15:0] busy_n;
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      busy_n <= 16'h0000;
    end else if (ce_in) begin
      busy_n <= fetch_busy_out ? busy_n + 16'h0001 : 16'h0000;
    end
  end
  chk_oe_deselect: assert property (
    csn_in [*8] |-> !miso_oe_out) else $error("output on while deselected");
  chk_oe_select: assert property (
    !csn_in [*8] |-> miso_oe_out) else $error("output off while selected");
  chk_refuse_pulse: assert property (
    write_refused_out |=> !write_refused_out) else $error("long refusal");
  chk_fetch_bound: assert property (
    busy_n <= FMAX) else $error("fetch too slow");
  chk_fetch_cfg: assert property (
    $rose(fetch_busy_out) && $past(sensor_state_in) != `SSR_ST_RUNNING
    |-> ##[1:CFG_MAX] !fetch_busy_out) else $error("config fetch too slow");
  chk_ll_commit: assert property (
    $changed(line_length_setting_out) |-> cfg || $past(cfg))
    else $error("line length changed outside config");
  chk_sub_commit: assert property (
    $changed(sub_lvds_en_out) |-> cfg || $past(cfg))
    else $error("signalling changed outside config");
  chk_tp_commit: assert property (
    $changed(test_pattern_out) |-> cfg || idl || $past(cfg || idl))
    else $error("pattern changed outside config or idle");
  chk_df_commit: assert property (
    $changed(defect_enable_out) |-> $past(frame_start_in) ||
    $past(frame_start_in, 2) || $past(frame_start_in, 3))
    else $error("defect setting changed without frame start");
  chk_miso_quiet: assert property (
    $changed(miso_out) |-> miso_oe_out)
    else $error("data output moved while deselected");
  chk_ce_freeze: assert property (
    !ce_in |=> $stable(defect_enable_out) && $stable(test_pattern_out) &&
    $stable(line_length_setting_out) && $stable(fetch_busy_out))
    else $error("state moved with clock enable low");
endmodule

// ### tb/ssr_master_model.sv
// Serial master standing for the application controller.
// Assumes the sensor slave opposite; clock idles high, rising edge samples.
`timescale 1ns/100ps
module ssr_master_model #(
  parameter int HALF_NS = 80
) (
  output logic csn_out,
  output logic sck_out,
  output logic mosi_out,
  input wire miso_in
);
  initial begin
    csn_out = 1'b1;
    sck_out = 1'b1;
    mosi_out = 1'b0;
  end
  task automatic xfer(input logic [15:0] adr, input logic [15:0] wdat,
                      input int stall_ns, output logic [15:0] rdat);
    logic [31:0] word;
    word = {adr, wdat};
    rdat = 16'h0000;
    // Keep every pin change clear of the sensor's sampling clock edge.
    #1;
    csn_out = 1'b0;
    #(HALF_NS);
    for (int i = 31; i >= 0; i--) begin
      if (i == 15) #(stall_ns);
      sck_out = 1'b0;
      mosi_out = word[i];
      #(HALF_NS);
      sck_out = 1'b1;
      if (i < 16) rdat = {rdat[14:0], miso_in};
      #(HALF_NS);
    end
    csn_out = 1'b1;
    // A released line must not keep its last value.
    mosi_out = ~mosi_out;
  endtask
endmodule

// ### tb/tb.sv
// Self-checking bench for the sensor serial slave and shadow store.
// Assumes logic/ on the include path and the master model beside it.
`timescale 1ns/100ps
`include "ssr_consts.vh"
module tb;
  localparam int STALL = 1600;
  logic ref_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic ce = 1'b1;
  logic [1:0] state = 2'h1;
  logic fs = 1'b0;
  wire csn, sck, mosi, miso, oe, sub_en, refused, busy;
  wire [15:0] ll, tp, df;
  // A released data line shows the inverse of its last driven value.
  wire miso_line = oe ? miso : !miso;
  int bad_count = 0;
  int n_compared = 0;
  int ref_n = 0;
  int n;
  logic [15:0] rd;
  always #2 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) begin
    if (refused === 1'b1) ref_n <= ref_n + 1;
  end
  ssr_spi_slave #(.FETCH_RUN_CYC(20)) ssr_spi_slave_i (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .ce_in(ce),
    .csn_in(csn), .sck_in(sck), .mosi_in(mosi), .miso_out(miso),
    .miso_oe_out(oe), .sensor_state_in(state), .frame_start_in(fs),
    .line_length_setting_out(ll), .sub_lvds_en_out(sub_en),
    .test_pattern_out(tp), .defect_enable_out(df),
    .write_refused_out(refused), .fetch_busy_out(busy));
  ssr_master_model ssr_master_model_i (.csn_out(csn), .sck_out(sck),
    .mosi_out(mosi), .miso_in(miso_line));
  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: %s: got %h expected %h", $time, what, got,
               exp);
    end
  endtask
  task automatic go(input logic [1:0] s);
    @(posedge ref_clk_in);
    state <= s;
    repeat (8) @(posedge ref_clk_in);
  endtask
  task automatic xf(input logic [15:0] a, input logic [15:0] d);
    ssr_master_model_i.xfer(a, d, STALL, rd);
    repeat (20) @(posedge ref_clk_in);
  endtask
  task automatic pulse_fs();
    @(posedge ref_clk_in);
    fs <= 1'b1;
    @(posedge ref_clk_in);
    fs <= 1'b0;
    repeat (6) @(posedge ref_clk_in);
  endtask
  task automatic t_reset();
    check({15'h0, oe}, 16'h0000, "output enable");
    check(ll, `SSR_RST_LINE_LEN, "line length");
    check({15'h0, sub_en}, `SSR_RST_LVDS_SEL & 16'h0001, "signalling");
    check(tp, `SSR_RST_TEST_PAT, "test pattern");
    check(df, `SSR_RST_DEFECT, "defect enable");
    check({14'h0, refused, busy}, 16'h0000, "refusal and fetch");
  endtask
  task automatic t_held();
    go(`SSR_ST_RUNNING);
    xf(`SSR_ADR_LINE_LEN, 16'h00aa);
    xf(`SSR_ADR_LVDS_SEL, 16'h0433);
    check(ll, 16'h0000, "line length held");
    check({15'h0, sub_en}, 16'h0000, "signalling held");
    xf(`SSR_ADR_LINE_LEN, 16'h00aa);
    check(rd, 16'h00aa, "shadow readback");
    go(`SSR_ST_CONFIG);
    go(`SSR_ST_RUNNING);
    check(ll, 16'h00aa, "line length applied");
    check({15'h0, sub_en}, 16'h0001, "signalling applied");
  endtask
  task automatic t_any();
    xf(`SSR_ADR_DEFECT, 16'h0005);
    check(df, 16'h0006, "defect before frame");
    ce <= 1'b0;
    pulse_fs();
    check(df, 16'h0006, "defect while frozen");
    ce <= 1'b1;
    pulse_fs();
    check(df, 16'h0005, "defect at frame");
    xf(`SSR_ADR_DEFECT, 16'h0005);
    check(rd, 16'h0005, "running readback");
  endtask
  task automatic t_cfg_idle();
    go(`SSR_ST_CONFIG);
    xf(`SSR_ADR_TEST_PAT, 16'h0022);
    check(rd, 16'h0011, "config readback");
    go(`SSR_ST_IDLE);
    check(tp, 16'h0022, "pattern at idle");
    n = ref_n;
    xf(`SSR_ADR_LINE_LEN, 16'h0111);
    check(16'(ref_n - n), 16'h0001, "idle refusal");
    go(`SSR_ST_CONFIG);
    check(ll, 16'h00aa, "refused write dropped");
    n = ref_n;
    xf(16'h1234, 16'h5555);
    check(16'(ref_n - n), 16'h0001, "unmapped refusal");
  endtask
  task automatic t_standby();
    go(`SSR_ST_STANDBY);
    n = ref_n;
    xf(`SSR_ADR_DEFECT, 16'h0007);
    check(16'(ref_n - n), 16'h0001, "standby refusal");
    xf(`SSR_ADR_STBY_A, 16'h0abc);
    xf(`SSR_ADR_STBY_A, 16'h0abc);
    check(rd, 16'h0abc, "first standby write");
    xf(`SSR_ADR_STBY_B, 16'h0def);
    xf(`SSR_ADR_STBY_B, 16'h0def);
    check(rd, 16'h0def, "second standby write");
    check(16'(ref_n - n), 16'h0001, "standby accept");
    xf(`SSR_ADR_DEFECT, 16'h0005);
    check(rd, 16'h0005, "refused write dropped");
  endtask
  task automatic close_out();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    repeat (12) @(posedge ref_clk_in);
    t_reset();
    t_held();
    t_any();
    t_cfg_idle();
    t_standby();
    close_out();
  end
  initial begin
    #300000;
    bad_count++;
    $display("ERROR at %0t: watchdog expired", $time);
    close_out();
  end
endmodule
bind ssr_spi_slave ssr_spi_checker #(.FETCH_RUN_CYC(FETCH_RUN_CYC)) chk_i (
  .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
  .csn_in(csn_in), .sck_in(sck_in), .mosi_in(mosi_in),
  .miso_out(miso_out), .miso_oe_out(miso_oe_out),
  .sensor_state_in(sensor_state_in), .frame_start_in(frame_start_in),
  .line_length_setting_out(line_length_setting_out),
  .sub_lvds_en_out(sub_lvds_en_out), .test_pattern_out(test_pattern_out),
  .defect_enable_out(defect_enable_out),
  .write_refused_out(write_refused_out), .fetch_busy_out(fetch_busy_out));
